/* logic/bioa_pkg.sv */
// Shared constants for the block I/O and add execution unit
package bioa_pkg;
  // Opcodes (low bit is the width bit)
  localparam logic [7:0] OP_ADD_MR_B = 8'h00;
  localparam logic [7:0] OP_ADD_RM_W = 8'h03;
  localparam logic [7:0] OP_BIN_B = 8'h6C;
  localparam logic [7:0] OP_BOUT_W = 8'h6F;
  localparam logic [7:0] OP_REP_NZ = 8'hF2;
  localparam logic [7:0] OP_REP = 8'hF3;
  localparam logic [7:0] OP_SEG_0 = 8'h26;
  localparam logic [7:0] OP_SEG_3 = 8'h3E;
  localparam logic [7:0] SEG_OP_MASK = 8'hE7;
  localparam int SEG_OP_POS = 3;
  // General register indices
  localparam logic [2:0] R_ACC = 3'h0;
  localparam logic [2:0] R_CNT = 3'h1;
  localparam logic [2:0] R_PORT = 3'h2;
  localparam logic [2:0] R_BW = 3'h3;
  localparam logic [2:0] R_BP = 3'h5;
  localparam logic [2:0] R_SRC = 3'h6;
  localparam logic [2:0] R_DST = 3'h7;
  // Segment indices: second data, program, stack, first data
  localparam logic [1:0] SG_DATA2 = 2'h0;
  localparam logic [1:0] SG_STACK = 2'h2;
  localparam logic [1:0] SG_DATA1 = 2'h3;
  // Flag positions
  localparam int F_CY = 0;
  localparam int F_P = 2;
  localparam int F_AC = 4;
  localparam int F_Z = 6;
  localparam int F_S = 7;
  localparam int F_DIR = 10;
  localparam int F_V = 11;
  localparam logic [15:0] FLAG_ARITH = 16'h08D5;
  localparam logic [15:0] FLAG_RESET = 16'hF002;
  // Register port map
  localparam logic [3:0] RA_SEG0 = 4'h8;
  localparam logic [3:0] RA_SEG3 = 4'hB;
  localparam logic [3:0] RA_FLAGS = 4'hC;
  localparam logic [3:0] RA_CONFIG = 4'hD;
  localparam logic [3:0] RA_STATUS = 4'hE;
  // Clock budgets
  localparam logic [23:0] CK_REGREG = 24'h2;
  localparam logic [23:0] CK_SINGLE_BASE = 24'h2;
  localparam logic [23:0] CK_REP_BASE = 24'h9;
  localparam logic [23:0] CK_ELEM_FAST = 24'h8;
  localparam logic [23:0] CK_ELEM_ODD = 24'h4;
  localparam logic [23:0] CK_ELEM_SLOW = 24'h10;
  localparam logic [23:0] CK_MR_FAST = 24'h10;
  localparam logic [23:0] CK_MR_SLOW = 24'h18;
  localparam logic [23:0] CK_RM_FAST = 24'hB;
  localparam logic [23:0] CK_RM_SLOW = 24'hF;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
endpackage

/* logic/bioa_fifo.sv */
// Instruction byte FIFO with registered ready and valid
`timescale 1ns/1ns
module bioa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic [WIDTH-1:0] inData, // Write data
  input wire logic inValid, // Write request
  output logic inReady, // Not full
  output logic [WIDTH-1:0] outData, // Head word
  output logic outValid, // Not empty
  input wire logic outReady // Pop
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("bioa_fifo: DEPTH must be a power of two >= 2");
    end
  end
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } bioa_fifo_t;
  bioa_fifo_t s_reg, s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign push = inValid && s_reg.rdy;
  assign pop = outReady && s_reg.vld;
  assign inReady = s_reg.rdy;
  assign outValid = s_reg.vld;
  assign outData = mem[s_reg.rp];
  always_comb begin
    s_next = s_reg;
    if (push) s_next.wp = s_reg.wp + 1'b1;
    if (pop) s_next.rp = s_reg.rp + 1'b1;
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_next.rdy = s_next.cnt != (AW+1)'(DEPTH);
    s_next.vld = s_next.cnt != '0;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
    end else if (ce) begin
      s_reg <= s_next;
      if (push) mem[s_reg.wp] <= inData;
    end
  end
endmodule

/* logic/bioa_alu.sv */
// Byte or word adder with the six arithmetic flags
`timescale 1ns/1ns
module bioa_alu import bioa_pkg::*; (
  input wire logic [15:0] a, // First operand
  input wire logic [15:0] b, // Second operand
  input wire logic w, // Word width
  output logic [15:0] sum, // Result
  output logic [15:0] flags // Flag image, arithmetic bits only
);
  logic [16:0] s17;
  logic [8:0] s9;
  logic msb, am, bm;
  always_comb begin
    s17 = {1'b0, a} + {1'b0, b};
    s9 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
    sum = w ? s17[15:0] : {8'h00, s9[7:0]};
    msb = w ? sum[15] : sum[7];
    am = w ? a[15] : a[7];
    bm = w ? b[15] : b[7];
    flags = 16'h0000;
    flags[F_CY] = w ? s17[16] : s9[8];
    flags[F_P] = ~^sum[7:0];
    flags[F_AC] = a[4] ^ b[4] ^ sum[4];
    flags[F_Z] = sum == 16'h0000;
    flags[F_S] = msb;
    flags[F_V] = (am == bm) && (msb != am);
  end
endmodule

/* logic/bioa_core.sv */
// Execution unit for block port I/O and binary add
`timescale 1ns/1ns
module bioa_core import bioa_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // Sync reset, high
  input wire logic ce, // Clock enable
  input wire logic [7:0] insData, // Instruction byte
  input wire logic insValid, // Instruction byte valid
  output logic insReady, // FIFO can take a byte
  output logic busReq, // Bus request, held to ack
  output logic busWrite, // Write when high
  output logic busIo, // I/O space when high
  output logic busWord, // Word access when high
  output logic [19:0] busAddr, // Physical or port address
  output logic [15:0] busWdata, // Write data
  input wire logic busAck, // Transfer done
  input wire logic [15:0] busRdata, // Read data with ack
  input wire logic [3:0] regAddr, // Register port address
  input wire logic [15:0] regWdata, // Register write data
  input wire logic regWr, // Register write strobe
  input wire logic regRd, // Register read strobe
  output logic [15:0] regRdata // Read data, cycle after strobe
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("bioa_core: FIFO_DEPTH must be at least 2");
    end
  end

  typedef enum logic [3:0] {
    S_FETCH, S_MODRM, S_DISP, S_ADDR, S_MRD, S_MWR,
    S_BSTART, S_B1, S_B2, S_WAIT
  } bioa_st_t;

  typedef enum logic [1:0] {K_ADD, K_BIN, K_BOUT} bioa_kind_t;

  typedef struct packed {
    bioa_st_t st;
    bioa_kind_t kind;
    logic [7:0][15:0] gpr;
    logic [3:0][15:0] seg;
    logic [15:0] flg;
    logic wide;
    logic rep;
    logic ovrEn;
    logic [1:0] ovrSeg;
    logic w;
    logic d;
    logic [1:0] md;
    logic [2:0] rf;
    logic [2:0] rm;
    logic [15:0] disp;
    logic [1:0] dispLeft;
    logic [19:0] maddr;
    logic [15:0] data;
    logic [23:0] cyc;
    logic [23:0] budget;
    logic [7:0] unsup;
    logic busReq;
    logic busWrite;
    logic busIo;
    logic busWord;
    logic [19:0] busAddr;
    logic [15:0] busWdata;
    logic [15:0] rdata;
  } bioa_state_t;

  bioa_state_t s_reg, s_next;
  logic [7:0] fData;
  logic fValid, fPop;
  logic [15:0] aluA, aluB, aluSum, aluFlags;

  bioa_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .inData(insData),
    .inValid(insValid),
    .inReady(insReady),
    .outData(fData),
    .outValid(fValid),
    .outReady(fPop)
  );

  bioa_alu u_alu (
    .a(aluA),
    .b(aluB),
    .w(s_reg.w),
    .sum(aluSum),
    .flags(aluFlags)
  );

  // Byte registers 4..7 are the high halves of 0..3
  function automatic logic [15:0] getReg(logic [7:0][15:0] g, logic [2:0] i,
                                         logic w);
    logic [15:0] v;
    v = g[{1'b0, i[1:0]}];
    if (w) return g[i];
    return i[2] ? {8'h00, v[15:8]} : {8'h00, v[7:0]};
  endfunction

  function automatic logic [7:0][15:0] putReg(logic [7:0][15:0] g,
                                              logic [2:0] i, logic w,
                                              logic [15:0] v);
    logic [7:0][15:0] r;
    r = g;
    if (w) r[i] = v;
    else if (i[2]) r[{1'b0, i[1:0]}][15:8] = v[7:0];
    else r[{1'b0, i[1:0]}][7:0] = v[7:0];
    return r;
  endfunction

  function automatic logic [19:0] phys(logic [15:0] sg, logic [15:0] off);
    return {sg, 4'h0} + {4'h0, off};
  endfunction

  // Index step: 1 or 2, down when the direction flag is set
  function automatic logic [15:0] step(logic [15:0] x, logic w, logic dn);
    logic [15:0] n;
    n = w ? 16'h0002 : 16'h0001;
    return dn ? x - n : x + n;
  endfunction

  function automatic logic [15:0] effAddr(logic [7:0][15:0] g, logic [1:0] md,
                                          logic [2:0] rm, logic [15:0] dp);
    logic [15:0] b;
    case (rm)
      3'h0: b = g[R_BW] + g[R_SRC];
      3'h1: b = g[R_BW] + g[R_DST];
      3'h2: b = g[R_BP] + g[R_SRC];
      3'h3: b = g[R_BP] + g[R_DST];
      3'h4: b = g[R_SRC];
      3'h5: b = g[R_DST];
      3'h6: b = (md == 2'h0) ? 16'h0000 : g[R_BP];
      default: b = g[R_BW];
    endcase
    return b + dp;
  endfunction

  function automatic logic [23:0] elemClk(logic w, logic wide, logic oddA,
                                          logic oddB);
    if (!w) return CK_ELEM_FAST;
    if (!wide) return CK_ELEM_SLOW;
    return CK_ELEM_FAST + (oddA ? CK_ELEM_ODD : 24'h0)
      + (oddB ? CK_ELEM_ODD : 24'h0);
  endfunction

  assign fPop = fValid && (s_reg.st == S_FETCH || s_reg.st == S_MODRM
                           || s_reg.st == S_DISP);

  // Operand pair: direction bit clear means memory or rm is destination
  always_comb begin
    aluA = s_reg.d ? getReg(s_reg.gpr, s_reg.rf, s_reg.w) : s_reg.data;
    aluB = s_reg.d ? s_reg.data : getReg(s_reg.gpr, s_reg.rf, s_reg.w);
    if (s_reg.st == S_MODRM) begin
      aluA = getReg(s_reg.gpr, fData[5:3], s_reg.w);
      aluB = getReg(s_reg.gpr, fData[2:0], s_reg.w);
      if (!s_reg.d) begin
        aluA = getReg(s_reg.gpr, fData[2:0], s_reg.w);
        aluB = getReg(s_reg.gpr, fData[5:3], s_reg.w);
      end
    end
  end

  always_comb begin
    logic [15:0] off;
    logic [15:0] cw;
    logic [1:0] sg;
    off = 16'h0000;
    cw = 16'h0000;
    sg = SG_DATA1;
    s_next = s_reg;
    s_next.cyc = s_reg.cyc + 24'h1;
    if (regWr) begin
      if (!regAddr[3]) s_next.gpr[regAddr[2:0]] = regWdata;
      else if (regAddr <= RA_SEG3) s_next.seg[regAddr[1:0]] = regWdata;
      else if (regAddr == RA_FLAGS) s_next.flg = regWdata;
      else if (regAddr == RA_CONFIG) s_next.wide = regWdata[0];
    end
    if (regRd) begin
      if (!regAddr[3]) s_next.rdata = s_reg.gpr[regAddr[2:0]];
      else if (regAddr <= RA_SEG3) s_next.rdata = s_reg.seg[regAddr[1:0]];
      else if (regAddr == RA_FLAGS) s_next.rdata = s_reg.flg;
      else if (regAddr == RA_CONFIG) s_next.rdata = {15'h0000, s_reg.wide};
      else if (regAddr == RA_STATUS) begin
        s_next.rdata = {s_reg.unsup, 2'h0, s_reg.rep, s_reg.ovrEn,
                        s_reg.st};
      end else s_next.rdata = 16'h0000;
    end
    case (s_reg.st)
      S_FETCH: begin
        if (fValid) begin
          s_next.cyc = 24'h1;
          s_next.w = fData[0];
          if (fData == OP_REP || fData == OP_REP_NZ) begin
            s_next.rep = 1'b1;
          end else if ((fData & SEG_OP_MASK) == OP_SEG_0) begin
            s_next.ovrEn = 1'b1;
            s_next.ovrSeg = fData[SEG_OP_POS+1:SEG_OP_POS];
          end else if (fData >= OP_BIN_B && fData <= OP_BOUT_W) begin
            s_next.kind = fData[1] ? K_BOUT : K_BIN;
            s_next.budget = s_reg.rep ? CK_REP_BASE : CK_SINGLE_BASE;
            s_next.st = S_BSTART;
          end else if (fData <= OP_ADD_RM_W) begin
            s_next.kind = K_ADD;
            s_next.d = fData[1];
            s_next.st = S_MODRM;
          end else begin
            s_next.unsup = s_reg.unsup + 8'h01;
            s_next.rep = 1'b0;
            s_next.ovrEn = 1'b0;
          end
        end
      end
      S_MODRM: begin
        if (fValid) begin
          s_next.md = fData[7:6];
          s_next.rf = fData[5:3];
          s_next.rm = fData[2:0];
          s_next.disp = 16'h0000;
          if (fData[7:6] == MOD_REG) begin
            s_next.gpr = putReg(s_reg.gpr, s_reg.d ? fData[5:3] : fData[2:0],
                                s_reg.w, aluSum);
            s_next.flg = (s_reg.flg & ~FLAG_ARITH) | aluFlags;
            s_next.rep = 1'b0;
            s_next.ovrEn = 1'b0;
            s_next.st = S_FETCH;
          end else begin
            if (fData[7:6] == 2'h1) s_next.dispLeft = 2'h1;
            else if (fData[7:6] == 2'h2) s_next.dispLeft = 2'h2;
            else if (fData[2:0] == RM_DIRECT) s_next.dispLeft = 2'h2;
            else s_next.dispLeft = 2'h0;
            s_next.st = (s_next.dispLeft == 2'h0) ? S_ADDR : S_DISP;
          end
        end
      end
      S_DISP: begin
        if (fValid) begin
          s_next.dispLeft = s_reg.dispLeft - 2'h1;
          if (s_reg.md == 2'h1) s_next.disp = {{8{fData[7]}}, fData};
          else if (s_reg.dispLeft == 2'h2) s_next.disp[7:0] = fData;
          else s_next.disp[15:8] = fData;
          if (s_reg.dispLeft == 2'h1) s_next.st = S_ADDR;
        end
      end
      S_ADDR: begin
        off = effAddr(s_reg.gpr, s_reg.md, s_reg.rm, s_reg.disp);
        sg = (s_reg.rm[2:1] == 2'h1 || (s_reg.rm == RM_DIRECT
              && s_reg.md != 2'h0)) ? SG_STACK : SG_DATA1;
        if (s_reg.ovrEn) sg = s_reg.ovrSeg;
        s_next.maddr = phys(s_reg.seg[sg], off);
        if (s_reg.d) begin
          s_next.budget = (s_reg.w && !(s_reg.wide && !off[0]))
            ? CK_RM_SLOW : CK_RM_FAST;
        end else begin
          s_next.budget = (s_reg.w && !(s_reg.wide && !off[0]))
            ? CK_MR_SLOW : CK_MR_FAST;
        end
        s_next.busReq = 1'b1;
        s_next.busWrite = 1'b0;
        s_next.busIo = 1'b0;
        s_next.busWord = s_reg.w;
        s_next.busAddr = s_next.maddr;
        s_next.st = S_MRD;
      end
      S_MRD: begin
        if (busAck) begin
          s_next.busReq = 1'b0;
          s_next.data = s_reg.w ? busRdata : {8'h00, busRdata[7:0]};
          s_next.st = S_WAIT;
        end
        if (s_reg.busReq == 1'b0) begin
          s_next.flg = (s_reg.flg & ~FLAG_ARITH) | aluFlags;
          if (s_reg.d) begin
            s_next.gpr = putReg(s_reg.gpr, s_reg.rf, s_reg.w, aluSum);
            s_next.st = S_WAIT;
          end else begin
            s_next.busReq = 1'b1;
            s_next.busWrite = 1'b1;
            s_next.busWdata = aluSum;
            s_next.st = S_MWR;
          end
        end else if (busAck) s_next.st = S_MRD;
      end
      S_MWR: begin
        if (busAck) begin
          s_next.busReq = 1'b0;
          s_next.st = S_WAIT;
        end
      end
      S_BSTART: begin
        cw = s_reg.gpr[R_CNT];
        if (s_reg.rep && cw == 16'h0000) begin
          s_next.st = S_WAIT;
        end else begin
          if (s_reg.kind == K_BIN) begin
            off = s_reg.gpr[R_DST];
            sg = SG_DATA2;
          end else begin
            off = s_reg.gpr[R_SRC];
            sg = s_reg.ovrEn ? s_reg.ovrSeg : SG_DATA1;
          end
          s_next.maddr = phys(s_reg.seg[sg], off);
          s_next.budget = s_reg.budget + elemClk(s_reg.w, s_reg.wide,
            s_reg.gpr[R_PORT][0], off[0]);
          s_next.busReq = 1'b1;
          s_next.busWrite = 1'b0;
          s_next.busWord = s_reg.w;
          s_next.busIo = s_reg.kind == K_BIN;
          s_next.busAddr = (s_reg.kind == K_BIN)
            ? {4'h0, s_reg.gpr[R_PORT]} : s_next.maddr;
          s_next.st = S_B1;
        end
      end
      S_B1: begin
        if (busAck) begin
          s_next.busWrite = 1'b1;
          s_next.busWdata = s_reg.w ? busRdata : {8'h00, busRdata[7:0]};
          s_next.busIo = s_reg.kind == K_BOUT;
          s_next.busAddr = (s_reg.kind == K_BOUT)
            ? {4'h0, s_reg.gpr[R_PORT]} : s_reg.maddr;
          s_next.st = S_B2;
        end
      end
      S_B2: begin
        if (busAck) begin
          s_next.busReq = 1'b0;
          if (s_reg.kind == K_BIN) begin
            s_next.gpr[R_DST] = step(s_reg.gpr[R_DST], s_reg.w,
                                     s_reg.flg[F_DIR]);
          end else begin
            s_next.gpr[R_SRC] = step(s_reg.gpr[R_SRC], s_reg.w,
                                     s_reg.flg[F_DIR]);
          end
          cw = s_reg.gpr[R_CNT] - 16'h0001;
          if (s_reg.rep) s_next.gpr[R_CNT] = cw;
          s_next.st = (s_reg.rep && cw != 16'h0000) ? S_BSTART : S_WAIT;
        end
      end
      S_WAIT: begin
        if (s_reg.cyc + 24'h1 >= s_reg.budget) begin
          s_next.rep = 1'b0;
          s_next.ovrEn = 1'b0;
          s_next.st = S_FETCH;
        end
      end
      default: s_next.st = S_FETCH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.flg <= FLAG_RESET;
      s_reg.st <= S_FETCH;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign busReq = s_reg.busReq;
  assign busWrite = s_reg.busWrite;
  assign busIo = s_reg.busIo;
  assign busWord = s_reg.busWord;
  assign busAddr = s_reg.busAddr;
  assign busWdata = s_reg.busWdata;
  assign regRdata = s_reg.rdata;
endmodule

/* sim/bioa_bus_model.sv */
// Memory and port model standing on the execution unit's bus
`timescale 1ns/1ns
module bioa_bus_model (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic slow, // Stretch each answer by three cycles
  input wire logic busReq, // Request
  input wire logic busWrite, // Write when high
  input wire logic busIo, // Port space
  input wire logic busWord, // Word access
  input wire logic [19:0] busAddr, // Address
  input wire logic [15:0] busWdata, // Write data
  output logic busAck, // Transfer done
  output logic [15:0] busRdata // Read data
);
  logic [7:0] mem [0:4095];
  logic [7:0] ioCnt;
  logic [1:0] waitCnt;
  logic [15:0] lastRd;
  logic [11:0] a;
  logic [15:0] rdVal;
  assign a = busAddr[11:0];
  assign rdVal = busIo ? {8'hB7, ioCnt} : {mem[a + 12'h001], mem[a]};
  assign busAck = busReq && (waitCnt == (slow ? 2'h3 : 2'h0));
  // Idle data lines flip so a stale value can never pass as fresh
  assign busRdata = (busAck && !busWrite) ? rdVal : ~lastRd;
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(posedge clk) begin
    if (rst) begin
      waitCnt <= 2'h0;
      ioCnt <= 8'h00;
      lastRd <= 16'h0000;
    end else begin
      waitCnt <= (busReq && !busAck) ? waitCnt + 2'h1 : 2'h0;
      if (busAck && !busWrite) lastRd <= rdVal;
      if (busAck && !busWrite && busIo) ioCnt <= ioCnt + 8'h01;
      if (busAck && busWrite && !busIo) begin
        mem[a] <= busWdata[7:0];
        if (busWord) mem[a + 12'h001] <= busWdata[15:8];
      end
    end
  end
endmodule

/* sim/bioa_core_sva.sv */
// Bus, data path and pointer checks for the execution unit
`timescale 1ns/1ns
module bioa_core_sva import bioa_pkg::*; (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic busReq, // Request
  input wire logic busWrite, // Write
  input wire logic busIo, // Port space
  input wire logic busWord, // Word
  input wire logic [19:0] busAddr, // Address
  input wire logic [15:0] busWdata, // Write data
  input wire logic busAck, // Done
  input wire logic [15:0] busRdata, // Read data
  input wire logic [3:0] regAddr, // Register address
  input wire logic [15:0] regWdata, // Register data
  input wire logic regWr // Register write
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic dirBit, lastIoRd, lastMemRd, inHave, outHave, portSeen;
  logic [19:0] inPrev, outPrev, memRdAddr;
  logic [15:0] lastPort;
  wire ack = busReq && busAck;
  wire [15:0] dataMask = busWord ? 16'hFFFF : 16'h00FF;
  wire [19:0] stepAmt = busWord ? 20'h00002 : 20'h00001;
  wire [19:0] stepExp = dirBit ? 20'h00000 - stepAmt : stepAmt;
  wire inWr = ack && busWrite && !busIo && lastIoRd;
  wire outWr = ack && busWrite && busIo && lastMemRd;
  // Any register write may move a pointer, so history is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      dirBit <= FLAG_RESET[F_DIR];
      lastIoRd <= 1'b0;
      lastMemRd <= 1'b0;
      inHave <= 1'b0;
      outHave <= 1'b0;
      portSeen <= 1'b0;
      inPrev <= 20'h00000;
      outPrev <= 20'h00000;
      memRdAddr <= 20'h00000;
      lastPort <= 16'h0000;
    end else begin
      if (regWr && regAddr == RA_FLAGS) dirBit <= regWdata[F_DIR];
      if (ack) lastIoRd <= busIo && !busWrite;
      if (ack) lastMemRd <= !busIo && !busWrite;
      if (ack && !busIo && !busWrite) memRdAddr <= busAddr;
      if (ack && busIo) lastPort <= busAddr[15:0];
      if (inWr) inPrev <= busAddr;
      if (outWr) outPrev <= memRdAddr;
      inHave <= !regWr && (inHave || inWr);
      outHave <= !regWr && (outHave || outWr);
      portSeen <= !regWr && (portSeen || (ack && busIo));
    end
  end
  sequence s_port_read;
    ack && busIo && !busWrite;
  endsequence
  sequence s_mem_read;
    ack && !busIo && !busWrite;
  endsequence
  a_fields_hold: assert property (busReq && !busAck |=> busReq && $stable(busAddr)
    && $stable({busWrite, busIo, busWord}) && $stable(busWdata)) else $error("bus fields moved");
  a_in_store: assert property (s_port_read |=> busReq && busWrite && !busIo
    && (busWdata & dataMask) == ($past(busRdata) & dataMask)) else $error("input data lost");
  a_in_width: assert property (s_port_read |=> busWord == $past(busWord))
    else $error("input width changed");
  a_out_send: assert property (s_mem_read ##1 (busReq && busIo) |-> busWrite
    && (busWdata & dataMask) == ($past(busRdata) & dataMask)) else $error("output data lost");
  a_out_width: assert property (s_mem_read ##1 (busReq && busIo) |->
    busWord == $past(busWord)) else $error("output width changed");
  a_port_fixed: assert property (busReq && busIo && portSeen |->
    busAddr[15:0] == lastPort) else $error("port address moved");
  a_in_step: assert property (inWr && inHave |-> busAddr - inPrev == stepExp)
    else $error("destination step wrong");
  // An override moves the base by whole paragraphs; the low nibble still shows the step
  a_out_step: assert property (outWr && outHave |-> memRdAddr[3:0] - outPrev[3:0] == stepExp[3:0])
    else $error("source step wrong");
endmodule
bind bioa_core bioa_core_sva u_bioa_core_sva (.clk, .rst, .busReq, .busWrite, .busIo,
  .busWord, .busAddr, .busWdata, .busAck, .busRdata, .regAddr, .regWdata, .regWr);

/* sim/tb.sv */
// Self-checking bench for the block I/O and add execution unit
`timescale 1ns/1ns
module tb;
  import bioa_pkg::*;
  logic clk, rst, insValid, insReady, busReq, busWrite, busIo, busWord, busAck;
  logic regWr, regRd, slow, ioPrev;
  logic [7:0] insData;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, busWdata, busRdata;
  logic [19:0] busAddr;
  int err_total, n_checks, cyc;
  int ioT[$];
  logic [15:0] ioD[$];
  logic [7:0] insQ[$];
  bioa_core u_bioa_core (.clk, .rst, .ce(1'b1), .insData, .insValid, .insReady, .busReq,
    .busWrite, .busIo, .busWord, .busAddr, .busWdata, .busAck, .busRdata, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata);
  bioa_bus_model u_bioa_bus_model (.clk, .rst, .slow, .busReq, .busWrite, .busIo,
    .busWord, .busAddr, .busWdata, .busAck, .busRdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkT(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask
  task automatic rdChk(input string what, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  // Pushes a byte stream, waits for its port transfers, then for idle state
  task automatic run(input logic [7:0] b[$], input int nIo);
    logic [15:0] d;
    ioT.delete();
    ioD.delete();
    @(negedge clk);
    foreach (b[i]) insQ.push_back(b[i]);
    for (int i = 0; i < 3000 && ioT.size() < nIo; i++) @(negedge clk);
    d = 16'h0001;
    for (int i = 0; i < 300 && d[3:0] != 4'h0; i++) rd(RA_STATUS, d);
  endtask
  function automatic logic [15:0] memW(input int a);
    return {u_bioa_bus_model.mem[a + 1], u_bioa_bus_model.mem[a]};
  endfunction
  // Add placed between two single inputs; spacing is 10 plus its budget
  task automatic addCase(input logic [15:0] acc, input logic [31:0] ins, input int n,
      input int tm, input logic [3:0] r, input logic [15:0] expR, input logic [15:0] expF);
    logic [7:0] q[$];
    wr({1'b0, R_ACC}, acc);
    wr({1'b0, R_CNT}, 16'h0001);
    q.push_back(OP_BIN_B);
    for (int i = 0; i < n; i++) q.push_back(ins[31 - 8 * i -: 8]);
    q.push_back(OP_BIN_B);
    run(q, 2);
    chkT("add clocks", tm, ioT[1] - ioT[0]);
    rdChk("add result", r, expR);
    rdChk("add flags", RA_FLAGS, expF);
  endtask
  always @(posedge clk) begin
    if (insValid && insReady) void'(insQ.pop_front());
    insValid <= insQ.size() != 0;
    insData <= insQ.size() != 0 ? insQ[0] : 8'h00;
  end
  always @(posedge clk) begin
    cyc++;
    ioPrev <= busReq && busIo;
    if (busReq && busIo && !ioPrev) begin
      ioT.push_back(cyc);
      chk("port", 16'h0040, busAddr[15:0]);
    end
    if (busReq && busAck && busIo && busWrite) ioD.push_back(busWdata);
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    $display("ERROR watchdog expected finish seen hang");
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    insValid = 1'b0;
    insData = 8'h00;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    slow = 1'b0;
    ioPrev = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdChk("flags reset", RA_FLAGS, FLAG_RESET);
    wr({1'b0, R_PORT}, 16'h0040);
    wr(RA_SEG0, 16'h0010);
    wr(RA_SEG3, 16'h0020);
    wr({1'b0, R_DST}, 16'h0000);
    wr({1'b0, R_CNT}, 16'h0003);
    run('{OP_BIN_B, OP_BIN_B, OP_REP, OP_BIN_B, OP_BIN_B}, 6);
    chkT("single byte", 10, ioT[1] - ioT[0]);
    chkT("repeat budget", 33, ioT[5] - ioT[2]);
    chkT("repeat span", 44, ioT[5] - ioT[1]);
    for (int k = 0; k < 6; k++) chk("in byte", 16'(k), memW(12'h100 + k) & 16'h00FF);
    rdChk("dst", {1'b0, R_DST}, 16'h0006);
    rdChk("count", {1'b0, R_CNT}, 16'h0000);
    rdChk("port reg", {1'b0, R_PORT}, 16'h0040);
    rdChk("io flags", RA_FLAGS, FLAG_RESET);
    $display("Test byte input done");
    wr(RA_FLAGS, 16'hF402);
    wr({1'b0, R_DST}, 16'h0020);
    run('{OP_BIN_B + 8'h01, OP_BIN_B + 8'h01}, 2);
    chkT("narrow word", 18, ioT[1] - ioT[0]);
    chk("word 0", 16'hB706, memW(12'h120));
    chk("word 1", 16'hB707, memW(12'h11E));
    rdChk("dst down", {1'b0, R_DST}, 16'h001C);
    wr(RA_CONFIG, 16'h0001);
    run('{OP_BIN_B + 8'h01, OP_BIN_B + 8'h01}, 2);
    chkT("wide even", 10, ioT[1] - ioT[0]);
    wr({1'b0, R_DST}, 16'h0021);
    run('{OP_BIN_B + 8'h01, OP_BIN_B + 8'h01}, 2);
    chkT("wide odd", 14, ioT[1] - ioT[0]);
    wr(RA_CONFIG, 16'h0000);
    wr(RA_FLAGS, FLAG_RESET);
    $display("Test word input done");
    slow <= 1'b1;
    wr({1'b0, R_SRC}, 16'h0010);
    run('{OP_BOUT_W - 8'h01, OP_SEG_0, OP_BOUT_W - 8'h01}, 2);
    chk("out default seg", 16'h004A, ioD[0] & 16'h00FF);
    chk("out override", 16'h004B, ioD[1] & 16'h00FF);
    wr({1'b0, R_CNT}, 16'h0002);
    run('{OP_REP_NZ, OP_BOUT_W}, 2);
    chk("out word 0", 16'h4948, ioD[0]);
    chk("out word 1", 16'h4F4E, ioD[1]);
    rdChk("src", {1'b0, R_SRC}, 16'h0016);
    slow <= 1'b0;
    $display("Test block output done");
    addCase(16'h7FFF, 32'h03C10000, 2, 12, {1'b0, R_ACC}, 16'h8000, 16'hF896);
    addCase(16'hFFFF, 32'h03C10000, 2, 12, {1'b0, R_ACC}, 16'h0000, 16'hF057);
    addCase(16'h8000, 32'h01064000, 4, 34, {1'b0, R_ACC}, 16'h8000, 16'hF082);
    chk("mem sum", 16'h9B1A, memW(12'h240));
    addCase(16'h0000, 32'h020E4200, 4, 21, {1'b0, R_CNT}, 16'h0019, FLAG_RESET);
    $display("Test add done");
    end_of_test();
  end
endmodule
